//--- hdl/cluster_pkg.sv
package cluster_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_ELEMENTS = 10;
    localparam int LUT_INPUTS = 4;
    localparam int LUT_BITS = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_CLEARS = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CLEAR_SEL_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] LUT_CHAIN_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] LUT_MASK_BASE_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] LUT_MASK_LAST_OFS = 8'h34;
    localparam logic [ADDR_W-1:0] REG_STATE_OFS = 8'h40;
    localparam logic [ADDR_W-1:0] LUT_STATE_OFS = 8'h44;
    localparam logic [ADDR_W-1:0] PIN_STATE_OFS = 8'h48;
    localparam int WORD_SHIFT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTRL_CLEAR_EN_BIT = 0;
    localparam int CTRL_SHIFT_MODE_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // Element data input roles
    localparam int LOAD_DATA_BIT = 3;
    localparam int SYNC_DATA_BIT = 0;
    localparam int CHAIN_DATA_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [NUM_ELEMENTS-1:0] SEL_RESET = 10'h000;
    localparam logic [LUT_BITS-1:0] LUT_MASK_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Cluster-wide controls, shared by every element
    typedef struct packed {
        logic [NUM_CLEARS-1:0] async_clear;
        logic async_load;
        logic load_high;
        logic sync_clear;
        logic sync_load;
        logic clock_enable;
    } cluster_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wr_data;
        logic wr_stb;
        logic rd_stb;
    } bus_req_t;

    typedef logic [NUM_ELEMENTS-1:0][LUT_BITS-1:0] lut_mask_array_t;
    typedef logic [NUM_ELEMENTS-1:0][LUT_INPUTS-1:0] element_data_t;

endpackage : cluster_pkg

//--- hdl/logic_element.sv
module logic_element #(
    parameter logic INIT_HIGH = 1'b0
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire cluster_pkg::cluster_ctrl_t ctrl,
    input wire logic chip_clear,
    input wire logic clear_sel,
    input wire logic [cluster_pkg::LUT_BITS-1:0] lut_mask,
    input wire logic [cluster_pkg::LUT_INPUTS-1:0] data_in,
    input wire logic lut_chain_in,
    input wire logic lut_chain_sel,
    input wire logic reg_chain_in,
    input wire logic shift_mode,
    output logic reg_q_r,
    output logic lut_out
);

    typedef struct packed {
        logic q;
    } element_state_t;

    element_state_t st_r;
    element_state_t st_nxt;
    logic [cluster_pkg::LUT_INPUTS-1:0] lut_in;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        lut_in = data_in;
        if (lut_chain_sel)
        begin
            lut_in[cluster_pkg::CHAIN_DATA_BIT] = lut_chain_in;
        end
        lut_out = lut_mask[lut_in];
        st_nxt = st_r;
        if (reset)
        begin
            st_nxt.q = INIT_HIGH;
        end
        else if (clk_en)
        begin
            if (chip_clear)
            begin
                st_nxt.q = 1'b0;
            end
            else if (ctrl.async_clear[clear_sel])
            begin
                st_nxt.q = 1'b0;
            end
            else if (ctrl.async_load)
            begin
                st_nxt.q = ctrl.load_high ? 1'b1 : data_in[cluster_pkg::LOAD_DATA_BIT];
            end
            else if (ctrl.sync_clear)
            begin
                st_nxt.q = 1'b0;
            end
            else if (ctrl.sync_load)
            begin
                st_nxt.q = data_in[cluster_pkg::SYNC_DATA_BIT];
            end
            else if (ctrl.clock_enable)
            begin
                st_nxt.q = shift_mode ? reg_chain_in : lut_out;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        st_r <= st_nxt;
    end

    assign reg_q_r = st_r.q;

endmodule : logic_element

//--- hdl/logic_cluster.sv
// Functional notes
// - Each register has a clear, and its preset is a load of a high level, not a set input.
// - Clear and preset or load together leave the register cleared.
// - A cluster offers at most two clear lines and one preset line, shared by all registers.
// - The enabled chip clear resets every register, beats every control, on its own route.
// - Chip clear held low through power-up keeps all clears on until the pin goes high.
// - A build option selects chip clear; when off the pin is a plain input with no reset effect.
// - Each register powers up low unless its own parameter selects high.
// - In shift mode each register feeds the register of the next element, elements 1 to 10.
// - An element's lookup output may drive the fast input of the element below it.
// - Clock, clears, preset or load, sync clear, sync load and enable are cluster-wide.
// - A load in normal mode captures the element's fourth data input.
module logic_cluster #(
    parameter logic [cluster_pkg::NUM_ELEMENTS-1:0] POWERUP_HIGH = 10'h000,
    parameter logic CHIP_CLEAR_OPTION = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire cluster_pkg::bus_req_t bus_req,
    output logic [cluster_pkg::DATA_W-1:0] rd_data_r,
    input wire logic chip_wide_clear_n,
    input wire cluster_pkg::cluster_ctrl_t ctrl,
    input wire cluster_pkg::element_data_t element_data,
    input wire logic shift_in,
    output logic [cluster_pkg::NUM_ELEMENTS-1:0] reg_q_r,
    output logic [cluster_pkg::NUM_ELEMENTS-1:0] lut_q_r,
    output logic pin_value_r
);

    typedef struct packed {
        logic clear_en;
        logic shift_mode;
        logic [cluster_pkg::NUM_ELEMENTS-1:0] clear_sel;
        logic [cluster_pkg::NUM_ELEMENTS-1:0] lut_chain_sel;
        cluster_pkg::lut_mask_array_t lut_mask;
        logic [cluster_pkg::DATA_W-1:0] rd_data;
        logic [cluster_pkg::NUM_ELEMENTS-1:0] lut_q;
        logic pin_value;
    } cluster_state_t;

    cluster_state_t st_r;
    cluster_state_t st_nxt;
    logic chip_clear;
    logic [cluster_pkg::NUM_ELEMENTS-1:0] lut_out;
    logic [cluster_pkg::NUM_ELEMENTS-1:0] reg_q;

    ////////////////////////////////////////////////////////////////////////////
    // Mask slot decode, shared by read and write
    function automatic logic mask_hit(input logic [cluster_pkg::ADDR_W-1:0] a);
        mask_hit = (a >= cluster_pkg::LUT_MASK_BASE_OFS)
            && (a <= cluster_pkg::LUT_MASK_LAST_OFS)
            && (a[cluster_pkg::WORD_SHIFT-1:0] == 2'h0);
    endfunction : mask_hit

    function automatic logic [3:0] mask_slot(input logic [cluster_pkg::ADDR_W-1:0] a);
        logic [cluster_pkg::ADDR_W-1:0] d;
        d = a - cluster_pkg::LUT_MASK_BASE_OFS;
        mask_slot = d[cluster_pkg::WORD_SHIFT+3:cluster_pkg::WORD_SHIFT];
    endfunction : mask_slot

    ////////////////////////////////////////////////////////////////////////////
    // option gates the pin's reset role
    // pin level held low keeps clears on
    assign chip_clear = CHIP_CLEAR_OPTION & st_r.clear_en & ~chip_wide_clear_n;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        if (reset)
        begin
            // Option preset so clears hold from power-up
            st_nxt.clear_en = CHIP_CLEAR_OPTION;
            st_nxt.shift_mode = 1'b0;
            st_nxt.clear_sel = cluster_pkg::SEL_RESET;
            st_nxt.lut_chain_sel = cluster_pkg::SEL_RESET;
            for (int i = 0; i < cluster_pkg::NUM_ELEMENTS; i++)
            begin
                st_nxt.lut_mask[i] = cluster_pkg::LUT_MASK_RESET;
            end
            st_nxt.rd_data = cluster_pkg::READ_ZERO;
            st_nxt.lut_q = cluster_pkg::SEL_RESET;
            st_nxt.pin_value = 1'b0;
        end
        else if (clk_en)
        begin
            st_nxt.lut_q = lut_out;
            st_nxt.pin_value = (CHIP_CLEAR_OPTION & st_r.clear_en) ? 1'b0 : chip_wide_clear_n;
            st_nxt.rd_data = cluster_pkg::READ_ZERO;
            if (bus_req.wr_stb)
            begin
                case (bus_req.addr)
                    cluster_pkg::CTRL_OFS:
                    begin
                        st_nxt.clear_en = bus_req.wr_data[cluster_pkg::CTRL_CLEAR_EN_BIT];
                        st_nxt.shift_mode = bus_req.wr_data[cluster_pkg::CTRL_SHIFT_MODE_BIT];
                    end
                    // each element picks one of two clears
                    cluster_pkg::CLEAR_SEL_OFS:
                    begin
                        st_nxt.clear_sel = bus_req.wr_data[cluster_pkg::NUM_ELEMENTS-1:0];
                    end
                    cluster_pkg::LUT_CHAIN_OFS:
                    begin
                        st_nxt.lut_chain_sel = bus_req.wr_data[cluster_pkg::NUM_ELEMENTS-1:0];
                    end
                    default:
                    begin
                        if (mask_hit(bus_req.addr))
                        begin
                            st_nxt.lut_mask[mask_slot(bus_req.addr)] =
                                bus_req.wr_data[cluster_pkg::LUT_BITS-1:0];
                        end
                    end
                endcase
            end
            if (bus_req.rd_stb)
            begin
                case (bus_req.addr)
                    cluster_pkg::CTRL_OFS:
                    begin
                        st_nxt.rd_data[cluster_pkg::CTRL_CLEAR_EN_BIT] = st_r.clear_en;
                        st_nxt.rd_data[cluster_pkg::CTRL_SHIFT_MODE_BIT] = st_r.shift_mode;
                    end
                    cluster_pkg::CLEAR_SEL_OFS:
                    begin
                        st_nxt.rd_data[cluster_pkg::NUM_ELEMENTS-1:0] = st_r.clear_sel;
                    end
                    cluster_pkg::LUT_CHAIN_OFS:
                    begin
                        st_nxt.rd_data[cluster_pkg::NUM_ELEMENTS-1:0] = st_r.lut_chain_sel;
                    end
                    cluster_pkg::REG_STATE_OFS:
                    begin
                        st_nxt.rd_data[cluster_pkg::NUM_ELEMENTS-1:0] = reg_q;
                    end
                    cluster_pkg::LUT_STATE_OFS:
                    begin
                        st_nxt.rd_data[cluster_pkg::NUM_ELEMENTS-1:0] = lut_out;
                    end
                    cluster_pkg::PIN_STATE_OFS:
                    begin
                        st_nxt.rd_data[0] = chip_wide_clear_n;
                    end
                    default:
                    begin
                        if (mask_hit(bus_req.addr))
                        begin
                            st_nxt.rd_data[cluster_pkg::LUT_BITS-1:0] =
                                st_r.lut_mask[mask_slot(bus_req.addr)];
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Elements; chains run from element 1 down to element 10
    for (genvar g = 0; g < cluster_pkg::NUM_ELEMENTS; g++)
    begin : g_element
        logic lut_up;
        logic reg_up;
        if (g == 0)
        begin : g_first
            assign lut_up = 1'b0;
            assign reg_up = shift_in;
        end
        else
        begin : g_rest
            assign lut_up = lut_out[g-1];
            assign reg_up = reg_q[g-1];
        end
        logic_element #(
            .INIT_HIGH(POWERUP_HIGH[g])
        ) u_element (
            .clk_sys(clk_sys),
            .reset(reset),
            .clk_en(clk_en),
            .ctrl(ctrl),
            .chip_clear(chip_clear),
            .clear_sel(st_r.clear_sel[g]),
            .lut_mask(st_r.lut_mask[g]),
            .data_in(element_data[g]),
            .lut_chain_in(lut_up),
            .lut_chain_sel(st_r.lut_chain_sel[g]),
            .reg_chain_in(reg_up),
            .shift_mode(st_r.shift_mode),
            .reg_q_r(reg_q[g]),
            .lut_out(lut_out[g])
        );
    end

    assign rd_data_r = st_r.rd_data;
    assign reg_q_r = reg_q;
    assign lut_q_r = st_r.lut_q;
    assign pin_value_r = st_r.pin_value;

endmodule : logic_cluster

//--- bench/control_source.sv
module control_source (
    input wire cluster_pkg::cluster_ctrl_t req,
    input wire logic hold_low,
    output cluster_pkg::cluster_ctrl_t ctrl,
    output logic chip_wide_clear_n
);
    timeunit 1ns;
    timeprecision 1ns;
    assign ctrl = req;
    assign chip_wide_clear_n = !hold_low;
endmodule : control_source

//--- bench/cluster_checker.sv
module cluster_checker #(
    parameter logic [9:0] POWERUP_HIGH = 10'h000,
    parameter logic CHIP_CLEAR_OPTION = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire cluster_pkg::bus_req_t bus_req,
    input wire logic chip_wide_clear_n,
    input wire cluster_pkg::cluster_ctrl_t ctrl,
    input wire cluster_pkg::element_data_t element_data,
    input wire logic shift_in,
    input wire logic [9:0] reg_q_r
);
    timeunit 1ns;
    timeprecision 1ns;
    logic en_r, shift_r, cc, quiet, idle;
    logic [9:0] d3, d0;
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the control bits, since the enable is not a port
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            en_r <= CHIP_CLEAR_OPTION;
            shift_r <= 1'b0;
        end
        else if (clk_en && bus_req.wr_stb && bus_req.addr == cluster_pkg::CTRL_OFS)
        begin
            en_r <= bus_req.wr_data[0];
            shift_r <= bus_req.wr_data[1];
        end
    end
    always_comb
    begin
        for (int i = 0; i < 10; i++)
        begin
            d3[i] = element_data[i][3];
            d0[i] = element_data[i][0];
        end
    end
    assign cc = clk_en && en_r && CHIP_CLEAR_OPTION && !chip_wide_clear_n;
    assign quiet = clk_en && !cc && ctrl.async_clear == 2'h0;
    assign idle = quiet && !ctrl.async_load && !ctrl.sync_clear && !ctrl.sync_load;
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    sequence s_pin_held;
        cc ##1 cc;
    endsequence
    a_chip_clear_wins: assert property (cc |=> reg_q_r == 10'h000)
        else $error("chip clear left a register set");
    a_clear_beats_load: assert property (clk_en && !cc && ctrl.async_clear == 2'h3
        ##0 ctrl.async_load |=> reg_q_r == 10'h000)
        else $error("load won over clear");
    a_preset_high: assert property (quiet && ctrl.async_load && ctrl.load_high
        |=> reg_q_r == 10'h3ff)
        else $error("preset did not load high");
    a_load_input_four: assert property (quiet && ctrl.async_load && !ctrl.load_high
        |=> reg_q_r == $past(d3))
        else $error("load did not take input four");
    a_sync_clear_order: assert property (quiet && !ctrl.async_load && ctrl.sync_clear
        |=> reg_q_r == 10'h000)
        else $error("sync clear lost");
    a_sync_load_data: assert property (quiet && !ctrl.async_load && !ctrl.sync_clear
        && ctrl.sync_load |=> reg_q_r == $past(d0))
        else $error("sync load data wrong");
    a_shift_chain: assert property (idle && ctrl.clock_enable && shift_r
        |=> reg_q_r == {$past(reg_q_r[8:0]), $past(shift_in)})
        else $error("register chain did not shift");
    a_hold_idle: assert property (idle && !ctrl.clock_enable |=> $stable(reg_q_r))
        else $error("register moved without enable");
    a_pin_hold: assert property (s_pin_held |-> reg_q_r == 10'h000)
        else $error("clear released while pin low");
    a_powerup_level: assert property ($fell(reset) |-> reg_q_r == POWERUP_HIGH)
        else $error("power-up level wrong");
endmodule : cluster_checker

bind logic_cluster cluster_checker #(.POWERUP_HIGH(POWERUP_HIGH),
    .CHIP_CLEAR_OPTION(CHIP_CLEAR_OPTION)) watch (.clk_sys(clk_sys), .reset(reset),
    .clk_en(clk_en), .bus_req(bus_req), .chip_wide_clear_n(chip_wide_clear_n), .ctrl(ctrl),
    .element_data(element_data), .shift_in(shift_in), .reg_q_r(reg_q_r));

//--- bench/logic_cluster_bench.sv
module logic_cluster_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        cluster_pkg::cluster_ctrl_t c;
        logic [9:0] b3;
        logic [9:0] b0;
        logic [9:0] exp;
    } row_t;
    localparam logic [9:0] PWR = 10'h2a5;
    logic clk_sys, reset, clk_en, shift_in, hold_low, chip_wide_clear_n;
    cluster_pkg::bus_req_t bus_req;
    cluster_pkg::cluster_ctrl_t req, ctrl;
    cluster_pkg::element_data_t element_data;
    logic [31:0] rd_data_r;
    logic [9:0] reg_q_r;
    logic [9:0] lut_q_r;
    logic pin_value_r;
    int error_cnt, comparisons;
    row_t rows [8];
    control_source partner (.req(req), .hold_low(hold_low), .ctrl(ctrl),
        .chip_wide_clear_n(chip_wide_clear_n));
    logic_cluster #(.POWERUP_HIGH(PWR)) DUT (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
        .bus_req(bus_req), .rd_data_r(rd_data_r), .chip_wide_clear_n(chip_wide_clear_n),
        .ctrl(ctrl), .element_data(element_data), .shift_in(shift_in), .reg_q_r(reg_q_r),
        .lut_q_r(lut_q_r), .pin_value_r(pin_value_r));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : chk
    task automatic cq(input logic [9:0] e);
        chk("reg_q_r", 32'(e), 32'(reg_q_r));
    endtask : cq
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus_req.wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus_req.rd_stb <= 1'b0;
        #1;
        chk("rd_data_r", exp, rd_data_r);
    endtask : rd
    // Controls go in right after an edge, result is seen n edges on
    task automatic apply(input cluster_pkg::cluster_ctrl_t c, input int n);
        @(posedge clk_sys);
        req <= c;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : apply
    function automatic cluster_pkg::element_data_t mk(input logic [9:0] b3, input logic [9:0] b0);
        cluster_pkg::element_data_t v;
        for (int i = 0; i < 10; i++)
        begin
            v[i] = {b3[i], 2'h0, b0[i]};
        end
        return v;
    endfunction : mk
    task automatic finish_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Whole run is well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        finish_test();
    end
    initial
    begin
        reset = 1'b1;
        clk_en = 1'b1;
        shift_in = 1'b0;
        hold_low = 1'b1;
        req = '0;
        bus_req = '0;
        element_data = '0;
        rows = '{
            '{7'h18, 10'h000, 10'h000, 10'h3ff},
            '{7'h38, 10'h000, 10'h000, 10'h000},
            '{7'h10, 10'h15a, 10'h000, 10'h15a},
            '{7'h78, 10'h3ff, 10'h000, 10'h000},
            '{7'h02, 10'h000, 10'h0c3, 10'h0c3},
            '{7'h00, 10'h000, 10'h3ff, 10'h0c3},
            '{7'h06, 10'h000, 10'h3ff, 10'h000},
            '{7'h58, 10'h000, 10'h000, 10'h3ff}};
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        cq(PWR);
        // Pin still held low from power-up, so preset must not land
        apply(7'h18, 3);
        cq(10'h000);
        hold_low <= 1'b0;
        apply(7'h18, 2);
        cq(10'h3ff);
        // Data and controls move together, else a held load grabs the next row's data
        foreach (rows[i])
        begin
            @(posedge clk_sys);
            element_data <= mk(rows[i].b3, rows[i].b0);
            req <= rows[i].c;
            repeat (2) @(posedge clk_sys);
            #1;
            cq(rows[i].exp);
        end
        wr(cluster_pkg::CLEAR_SEL_OFS, 32'h0000_000f);
        apply(7'h58, 1);
        cq(10'h3f0);
        rd(cluster_pkg::REG_STATE_OFS, 32'h0000_03f0);
        apply(7'h04, 1);
        wr(cluster_pkg::CTRL_OFS, 32'h0000_0003);
        @(posedge clk_sys);
        req <= 7'h01;
        shift_in <= 1'b1;
        @(posedge clk_sys);
        shift_in <= 1'b0;
        @(posedge clk_sys);
        shift_in <= 1'b1;
        apply(7'h00, 1);
        cq(10'h005);
        chk("pin_value_r", 32'h0000_0000, 32'(pin_value_r));
        wr(cluster_pkg::CTRL_OFS, 32'h0000_0001);
        wr(cluster_pkg::LUT_MASK_BASE_OFS, 32'h0000_0200);
        wr(8'h14, 32'h0000_0002);
        wr(cluster_pkg::LUT_CHAIN_OFS, 32'h0000_0002);
        element_data <= mk(10'h001, 10'h001);
        rd(cluster_pkg::LUT_STATE_OFS, 32'h0000_0003);
        chk("lut_q_r", 32'h0000_0003, 32'(lut_q_r));
        wr(cluster_pkg::CTRL_OFS, 32'h0000_0000);
        hold_low <= 1'b1;
        apply(7'h18, 2);
        cq(10'h3ff);
        // Enable low must freeze the registers against a sync clear
        clk_en <= 1'b0;
        apply(7'h04, 2);
        cq(10'h3ff);
        clk_en <= 1'b1;
        rd(cluster_pkg::PIN_STATE_OFS, 32'h0000_0000);
        hold_low <= 1'b0;
        rd(cluster_pkg::PIN_STATE_OFS, 32'h0000_0001);
        chk("pin_value_r", 32'h0000_0001, 32'(pin_value_r));
        rd(8'h80, 32'h0000_0000);
        finish_test();
    end
endmodule : logic_cluster_bench
